// ===== src/lfs_channel.sv
// lfs_channel: per-channel good/open/short classification and disable
// assumes sense inputs synchronous to clk_sys_in
`timescale 1ns/100ps
module lfs_channel (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic restart_in,
    input wire logic active_in,
    input wire lfs_pkg::lfs_ch_sense_s sense_in,
    input wire lfs_pkg::lfs_global_sense_s glob_in,
    input wire logic [1:0] level_in,
    input wire logic short_en_in,
    input wire logic pwm_period_in,
    output logic good_out,
    output logic open_out,
    output logic short_out,
    output logic off_out
);
    lfs_pkg::lfs_ch_state_e state_q, state_d;
    logic [2:0] tmo_q, tmo_d;
    logic short_q;

    // ***************************************************************
    // classification
    // ***************************************************************
    wire over_thr = (level_in == lfs_pkg::LEVEL_3V) ? sense_in.over_3v :
                    (level_in == lfs_pkg::LEVEL_5V) ? sense_in.over_5v : sense_in.over_4v;
    wire short_hit = short_en_in && over_thr && glob_in.stable && active_in;
    wire go_open_all = glob_in.ovp || glob_in.temp_low;
    wire low_open = glob_in.temp_low && sense_in.well_below;
    wire tmo_done = (tmo_q == 3'(lfs_pkg::OPEN_TIMEOUT_PERIODS));

    always_comb
    begin
        state_d = state_q;
        tmo_d = tmo_q;
        case (state_q)
            lfs_pkg::CH_IDLE:
            begin
                if (sense_in.at_target)
                    state_d = lfs_pkg::CH_GOOD;
                else if (go_open_all && active_in)
                    state_d = lfs_pkg::CH_OPEN;
                tmo_d = 3'h0;
            end
            lfs_pkg::CH_GOOD:
            begin
                // zener strings keep current up, so well_below at temp_low also sends them to open
                if ((!sense_in.at_target || low_open) && glob_in.stable)
                    state_d = lfs_pkg::CH_OPEN;
                tmo_d = 3'h0;
            end
            lfs_pkg::CH_OPEN:
            begin
                if (sense_in.at_target && !go_open_all && !low_open)
                begin
                    state_d = lfs_pkg::CH_GOOD;
                    tmo_d = 3'h0;
                end
                else if (tmo_done)
                    state_d = lfs_pkg::CH_OFF;
                else if (pwm_period_in)
                    tmo_d = tmo_q + 3'h1;
            end
            lfs_pkg::CH_OFF:
                state_d = lfs_pkg::CH_OFF;
            default:
                state_d = lfs_pkg::CH_IDLE;
        endcase
        if (restart_in)
        begin
            state_d = lfs_pkg::CH_IDLE;
            tmo_d = 3'h0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q <= lfs_pkg::CH_IDLE;
            tmo_q <= 3'h0;
            short_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tmo_q <= tmo_d;
            short_q <= restart_in ? 1'b0 : (short_q | short_hit);
        end
    end

    assign good_out = (state_q == lfs_pkg::CH_GOOD);
    assign open_out = (state_q == lfs_pkg::CH_OPEN) || (state_q == lfs_pkg::CH_OFF);
    assign short_out = short_q;
    assign off_out = (state_q == lfs_pkg::CH_OFF) || short_q;

endmodule : lfs_channel

// ===== src/lfs_ctrl.sv
// lfs_ctrl: led backlight supervisor with soft-start, fault handling and registers
// assumes a byte register port driven by a serial slave outside this block
`timescale 1ns/100ps

// ***************************************************************
// top level
// ***************************************************************
module lfs_ctrl (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic chip_en_in,
    input wire logic input_undervoltage_lockout_in,
    input wire logic led_enable_in,
    input wire logic conducting_in,
    input wire logic pwm_period_in,
    input wire lfs_pkg::lfs_ch_sense_s [lfs_pkg::NUM_CH-1:0] ch_sense_in,
    input wire lfs_pkg::lfs_global_sense_s glob_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic [3:0] current_limit_step_out,
    output logic boost_en_out,
    output logic [lfs_pkg::NUM_CH-1:0] ch_en_out,
    output logic [lfs_pkg::NUM_CH-1:0] ch_open_out,
    output logic [lfs_pkg::NUM_CH-1:0] ch_short_out
);
    logic [7:0] cfg_q;
    logic [7:0] status_q;
    logic [7:0] rdata_q;
    logic ack_q;
    logic [3:0] step_q;
    logic [31:0] tick_q;
    logic cond_q;
    logic led_en_q;
    logic input_undervoltage_lockout_q;
    logic therm_q;
    logic alloff_q;
    logic [lfs_pkg::NUM_CH-1:0] good_w, open_w, short_w, off_w;

    // ***************************************************************
    // global control
    // ***************************************************************
    // undervoltage lockout and chip disable act as a synchronous soft reset
    wire soft_rst = input_undervoltage_lockout_in || !chip_en_in;
    wire led_on = led_en_q && !input_undervoltage_lockout_q && !therm_q;
    wire restart = (led_enable_in && !led_en_q) || soft_rst;
    wire sel_status = (reg_addr_in == lfs_pkg::ADDR_FAULT_STATUS);
    wire sel_cfg = (reg_addr_in == lfs_pkg::ADDR_PROT_CONFIG);
    wire bus_ok = chip_en_in;
    wire cfg_wr = reg_wr_in && sel_cfg && bus_ok;
    wire [1:0] lvl_raw = cfg_q[lfs_pkg::CFG_LEVEL_LSB +: 2];
    wire [1:0] level = (lvl_raw == 2'h3) ? lfs_pkg::LEVEL_4V : lvl_raw;
    wire short_en = !cfg_q[lfs_pkg::CFG_SHORT_DIS_BIT];
    wire tick_done = (tick_q == 32'(lfs_pkg::STEP_CYCLES - 1));
    wire step_adv = tick_done && (cond_q || conducting_in) && (step_q != 4'(lfs_pkg::SS_STEPS));
    wire [3:0] short_cnt;
    wire new_fault = |(off_w & ~short_w);
    // a further short on top of three shorted channels also counts as another fault
    wire limit_hit = (short_cnt > 4'(lfs_pkg::SHORT_LIMIT)) || new_fault;
    wire all_off = alloff_q || ((short_cnt >= 4'(lfs_pkg::SHORT_LIMIT)) && limit_hit);

    // count shorted channels
    function automatic logic [3:0] popcnt(input logic [lfs_pkg::NUM_CH-1:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < lfs_pkg::NUM_CH; i++)
            c = c + {3'h0, v[i]};
        return c;
    endfunction : popcnt
    assign short_cnt = popcnt(short_w);

    // ***************************************************************
    // channels
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < lfs_pkg::NUM_CH; g++)
        begin : g_ch
            lfs_channel u_ch (
                .clk_sys_in(clk_sys_in),
                .resetn_in(resetn_in),
                .restart_in(restart),
                .active_in(led_on),
                .sense_in(ch_sense_in[g]),
                .glob_in(glob_in),
                .level_in(level),
                .short_en_in(short_en),
                .pwm_period_in(pwm_period_in),
                .good_out(good_w[g]),
                .open_out(open_w[g]),
                .short_out(short_w[g]),
                .off_out(off_w[g])
            );
        end
    endgenerate

    // ***************************************************************
    // soft-start sequencer
    // ***************************************************************
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            step_q <= 4'h1;
            tick_q <= 32'h0;
            cond_q <= 1'b0;
        end
        else if (restart || !led_on)
        begin
            step_q <= 4'h1;
            tick_q <= 32'h0;
            cond_q <= 1'b0;
        end
        else
        begin
            if (step_adv)
            begin
                step_q <= step_q + 4'h1;
                cond_q <= 1'b0;
                tick_q <= 32'h0;
            end
            else
            begin
                cond_q <= cond_q | conducting_in;
                tick_q <= tick_done ? tick_q : tick_q + 32'h1;
            end
        end
    end

    // ***************************************************************
    // enable, fault latches and registers
    // ***************************************************************
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cfg_q <= lfs_pkg::CFG_RESET;
            led_en_q <= 1'b0;
            input_undervoltage_lockout_q <= 1'b0;
            therm_q <= 1'b0;
            alloff_q <= 1'b0;
            status_q <= 8'h0;
        end
        else if (soft_rst)
        begin
            cfg_q <= lfs_pkg::CFG_RESET;
            led_en_q <= 1'b0;
            input_undervoltage_lockout_q <= input_undervoltage_lockout_in;
            therm_q <= 1'b0;
            alloff_q <= 1'b0;
            status_q <= 8'h0;
        end
        else
        begin
            if (cfg_wr)
                cfg_q <= reg_wdata_in;
            led_en_q <= led_enable_in;
            // lockout and thermal latch clear on host disable; soft reset loads them with the lockout input and zero
            if (!led_enable_in)
            begin
                input_undervoltage_lockout_q <= 1'b0;
                therm_q <= 1'b0;
                alloff_q <= 1'b0;
            end
            else
            begin
                therm_q <= therm_q | glob_in.temp_high;
                alloff_q <= all_off;
            end
            status_q[lfs_pkg::FS_THERMAL_BIT] <= status_q[lfs_pkg::FS_THERMAL_BIT] | glob_in.temp_high;
            status_q[lfs_pkg::FS_OPEN_BIT] <= status_q[lfs_pkg::FS_OPEN_BIT] | (|open_w);
            status_q[lfs_pkg::FS_SHORT_BIT] <= status_q[lfs_pkg::FS_SHORT_BIT] | (|short_w);
            status_q[lfs_pkg::FS_OVP_BIT] <= status_q[lfs_pkg::FS_OVP_BIT] | glob_in.ovp;
            status_q[lfs_pkg::FS_ALLOFF_BIT] <= status_q[lfs_pkg::FS_ALLOFF_BIT] | all_off;
            status_q[lfs_pkg::FS_SS_DONE_BIT] <= (step_q == 4'(lfs_pkg::SS_STEPS));
            status_q[7:6] <= 2'h0;
        end
    end

    // ***************************************************************
    // register read port
    // ***************************************************************
    wire [7:0] rd_mux = sel_status ? status_q : (sel_cfg ? cfg_q : 8'h00);

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
        end
        else
        begin
            if (reg_rd_in && bus_ok)
                rdata_q <= rd_mux;
            ack_q <= (reg_rd_in || reg_wr_in) && bus_ok;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign reg_rdata_out = rdata_q;
    assign reg_ack_out = ack_q;
    assign current_limit_step_out = led_on ? step_q : 4'h0;
    assign boost_en_out = led_on && !alloff_q && !soft_rst;
    assign ch_en_out = (led_on && !alloff_q && !soft_rst) ? ~off_w : '0;
    assign ch_open_out = open_w;
    assign ch_short_out = short_w;

endmodule : lfs_ctrl

// ===== src/lfs_pkg.sv
// lfs_pkg: constants and types for the led fault and soft-start supervisor
// assumes a 250 MHz system clock and an external byte-wide register port
package lfs_pkg;

    // ***************************************************************
    // clocking and timing
    // ***************************************************************
    localparam int CLK_MHZ = 250;
    localparam int STEP_TIME_US = 2000;
    localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
    localparam int NUM_CH = 8;
    localparam int SS_STEPS = 8;
    localparam int SS_DIVISOR = 9;
    localparam int OPEN_TIMEOUT_PERIODS = 6;
    localparam int SHORT_LIMIT = 3;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h02;
    localparam logic [7:0] ADDR_PROT_CONFIG = 8'h0f;

    // protection_config fields
    localparam int CFG_LEVEL_LSB = 0;
    localparam int CFG_SHORT_DIS_BIT = 2;
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [1:0] LEVEL_3V = 2'h0;
    localparam logic [1:0] LEVEL_4V = 2'h1;
    localparam logic [1:0] LEVEL_5V = 2'h2;

    // fault_status fields
    localparam int FS_THERMAL_BIT = 0;
    localparam int FS_OPEN_BIT = 1;
    localparam int FS_SHORT_BIT = 2;
    localparam int FS_OVP_BIT = 3;
    localparam int FS_ALLOFF_BIT = 4;
    localparam int FS_SS_DONE_BIT = 5;

    // ***************************************************************
    // types
    // ***************************************************************
    typedef struct packed {
        logic at_target;
        logic well_below;
        logic over_3v;
        logic over_4v;
        logic over_5v;
    } lfs_ch_sense_s;

    typedef struct packed {
        logic ovp;
        logic temp_low;
        logic temp_high;
        logic stable;
    } lfs_global_sense_s;

    typedef enum logic [3:0] {
        CH_IDLE = 4'b0001,
        CH_GOOD = 4'b0010,
        CH_OPEN = 4'b0100,
        CH_OFF = 4'b1000
    } lfs_ch_state_e;

endpackage : lfs_pkg

// ===== test/lfs_ctrl_assertions.sv
// lfs_ctrl_assertions: port-level checks for the led supervisor
// assumes binding to lfs_ctrl, one clock domain, async active-low reset
`timescale 1ns/100ps
module lfs_ctrl_assertions (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic chip_en_in,
    input wire logic input_undervoltage_lockout_in,
    input wire logic led_enable_in,
    input wire lfs_pkg::lfs_global_sense_s glob_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_ack_out,
    input wire logic [3:0] current_limit_step_out,
    input wire logic boost_en_out,
    input wire logic [lfs_pkg::NUM_CH-1:0] ch_en_out,
    input wire logic [lfs_pkg::NUM_CH-1:0] ch_open_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    wire req_taken = (reg_rd_in || reg_wr_in) && chip_en_in;
    wire unmapped = reg_addr_in != lfs_pkg::ADDR_FAULT_STATUS && reg_addr_in != lfs_pkg::ADDR_PROT_CONFIG;
    wire start_ok = chip_en_in && !input_undervoltage_lockout_in && !glob_in.temp_high;

    a_ack_follows_req: assert property (req_taken |=> reg_ack_out) else $error("no ack");
    a_no_ack_off: assert property ((reg_rd_in || reg_wr_in) && !chip_en_in |=> !reg_ack_out) else $error("ack off");
    a_unmapped_reads_zero: assert property (req_taken && reg_rd_in && unmapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped data");
    a_step_in_range: assert property (current_limit_step_out <= 4'h8) else $error("step range");
    a_step_no_skip: assert property ($changed(current_limit_step_out) && current_limit_step_out > 4'h1 |->
        current_limit_step_out == $past(current_limit_step_out) + 4'h1) else $error("step skip");
    a_restart_first: assert property ($rose(led_enable_in) && start_ok |-> ##[1:2] current_limit_step_out == 4'h1)
        else $error("no restart");
    a_hot_boost_off: assert property (glob_in.temp_high |-> ##[1:2] !boost_en_out) else $error("hot boost");
    a_lockout_off: assert property (input_undervoltage_lockout_in |-> ##[0:1] !boost_en_out)
        else $error("lockout boost");
    a_chip_off: assert property (!chip_en_in |-> !boost_en_out ##1 ch_en_out == 8'h00) else $error("chip off");
    a_open_waits: assert property ($rose(ch_open_out[1]) |-> ch_en_out[1] [*2]) else $error("open early");

    c_read: cover property (req_taken && reg_rd_in);
    c_open: cover property ($rose(ch_open_out[1]));
    c_hot: cover property (glob_in.temp_high);
    c_all_off: cover property ($fell(boost_en_out) && chip_en_in && !glob_in.temp_high);
endmodule : lfs_ctrl_assertions

// ===== test/lfs_host_model.sv
// lfs_host_model: host side of the byte register port
// assumes requests are taken on the rising edge of clk_sys_in
`timescale 1ns/100ps
module lfs_host_model (
    input wire logic clk_sys_in,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out
);
    initial
    begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h55;
        reg_wdata_out = 8'haa;
    end
    // one request held over one rising edge, then address and data scrambled
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys_in);
        reg_wr_out = wr;
        reg_rd_out = ~wr;
        reg_addr_out = addr;
        reg_wdata_out = data;
        @(negedge clk_sys_in);
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = ~addr;
        reg_wdata_out = ~data;
    endtask : xfer
endmodule : lfs_host_model

// ===== test/test_lfs_ctrl.sv
// test_lfs_ctrl: self-checking bench for lfs_ctrl
// assumes lfs_pkg, lfs_host_model and lfs_ctrl_assertions are compiled first
`timescale 1ns/100ps
module test_lfs_ctrl;
    logic clk_sys_in, resetn_in, chip_en_in, lockout, led_enable_in, conducting_in, pwm_period_in;
    lfs_pkg::lfs_ch_sense_s [lfs_pkg::NUM_CH-1:0] ch_sense_in;
    lfs_pkg::lfs_global_sense_s glob_in;
    logic reg_wr_in, reg_rd_in, reg_ack_out, boost_en_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, ch_en_out, ch_open_out, ch_short_out, rnd;
    logic [3:0] current_limit_step_out;
    logic [8:0] exp_q[$];
    logic [8:0] note;
    int n_errors = 0;
    int checks = 0;

    lfs_host_model u_host (.clk_sys_in, .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
        .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
    lfs_ctrl u_dut (.clk_sys_in, .resetn_in, .chip_en_in, .input_undervoltage_lockout_in(lockout),
        .led_enable_in, .conducting_in, .pwm_period_in, .ch_sense_in, .glob_in, .reg_wr_in, .reg_rd_in,
        .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .current_limit_step_out, .boost_en_out,
        .ch_en_out, .ch_open_out, .ch_short_out);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({1'b1, e});
        u_host.xfer(1'b0, a, 8'h00);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        exp_q.push_back(9'h000);
        u_host.xfer(1'b1, a, d);
    endtask : wr
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : wait_n
    task automatic pulse;
        @(negedge clk_sys_in);
        pwm_period_in = 1'b1;
        @(negedge clk_sys_in);
        pwm_period_in = 1'b0;
    endtask : pulse
    task automatic stop_test;
        chk(8'(exp_q.size()), 8'h00);
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // ***************************************************************
    // answer watcher
    // ***************************************************************
    always @(posedge clk_sys_in)
        if (reg_ack_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(8'h01, 8'h00);
            else
            begin
                note = exp_q.pop_front();
                if (note[8])
                    chk(reg_rdata_out, note[7:0]);
            end
        end

    initial
    begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        #40000;
        n_errors++;
        stop_test();
    end

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial
    begin
        resetn_in = 1'b0;
        chip_en_in = 1'b1;
        lockout = 1'b0;
        led_enable_in = 1'b0;
        conducting_in = 1'b1;
        pwm_period_in = 1'b0;
        ch_sense_in = '0;
        glob_in = '0;
        void'($urandom(32'h955c3e82));
        wait_n(16);
        resetn_in = 1'b1;
        rd(8'h0f, lfs_pkg::CFG_RESET);
        rd(8'h02, 8'h00);
        for (int lv = 0; lv < 3; lv++)
        begin
            wr(8'h0f, 8'(lv));
            rd(8'h0f, 8'(lv));
        end
        rnd = 8'($urandom);
        wr(8'h02, rnd);
        rd(8'h02, 8'h00);
        rnd = (rnd == 8'h02 || rnd == 8'h0f) ? 8'h10 : rnd;
        rd(rnd, 8'h00);
        wr(8'h0f, 8'h04);
        led_enable_in = 1'b1;
        wait_n(3);
        chk(8'(current_limit_step_out), 8'h01);
        ch_sense_in[0].over_3v = 1'b1;
        ch_sense_in[0].over_4v = 1'b1;
        ch_sense_in[2].over_3v = 1'b1;
        wait_n(4);
        chk(ch_short_out, 8'h00);
        wr(8'h0f, 8'h02);
        wait_n(4);
        chk(ch_short_out, 8'h00);
        wr(8'h0f, 8'h01);
        wait_n(4);
        chk(ch_short_out, 8'h00);
        glob_in.stable = 1'b1;
        wait_n(4);
        chk(ch_short_out, 8'h01);
        chk(8'(ch_en_out[0]), 8'h00);
        ch_sense_in[1].at_target = 1'b1;
        wait_n(4);
        chk(8'(ch_open_out[1]), 8'h00);
        ch_sense_in[1].at_target = 1'b0;
        wait_n(3);
        chk(8'(ch_open_out[1]), 8'h01);
        repeat (5) pulse();
        chk(8'(ch_en_out[1]), 8'h01);
        pulse();
        wait_n(2);
        chk(8'(ch_en_out[1]), 8'h00);
        chk(8'(ch_en_out[7:2]), 8'h3f);
        rd(8'h02, 8'h06);
        glob_in.temp_high = 1'b1;
        wait_n(2);
        glob_in.temp_high = 1'b0;
        wait_n(2);
        chk(8'(boost_en_out), 8'h00);
        chk(ch_en_out, 8'h00);
        rd(8'h02, 8'h07);
        led_enable_in = 1'b0;
        wait_n(2);
        led_enable_in = 1'b1;
        wait_n(3);
        chk(8'(current_limit_step_out), 8'h01);
        chk(8'(boost_en_out), 8'h01);
        ch_sense_in[3].at_target = 1'b1;
        ch_sense_in[4].at_target = 1'b1;
        wait_n(2);
        glob_in.temp_low = 1'b1;
        ch_sense_in[3].well_below = 1'b1;
        wait_n(2);
        chk(8'(ch_open_out[3]), 8'h01);
        chk(ch_open_out, 8'hef);
        glob_in.temp_low = 1'b0;
        ch_sense_in[2].over_4v = 1'b1;
        ch_sense_in[3].over_4v = 1'b1;
        ch_sense_in[4].over_4v = 1'b1;
        wait_n(3);
        chk(ch_short_out, 8'h1d);
        chk(8'(boost_en_out), 8'h00);
        chk(ch_en_out, 8'h00);
        wr(8'h0f, 8'h02);
        lockout = 1'b1;
        wait_n(2);
        chk(8'(boost_en_out), 8'h00);
        lockout = 1'b0;
        wait_n(2);
        chk(8'(boost_en_out), 8'h00);
        rd(8'h0f, 8'h01);
        chip_en_in = 1'b0;
        u_host.xfer(1'b0, 8'h0f, 8'h00);
        chk(8'(boost_en_out), 8'h00);
        chip_en_in = 1'b1;
        wait_n(4);
        stop_test();
    end
endmodule : test_lfs_ctrl

bind lfs_ctrl lfs_ctrl_assertions u_chk (.clk_sys_in, .resetn_in, .chip_en_in, .input_undervoltage_lockout_in,
    .led_enable_in, .glob_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out, .reg_ack_out,
    .current_limit_step_out, .boost_en_out, .ch_en_out, .ch_open_out);
